/* logic/vps_pkg.sv */
`default_nettype none
package vps_pkg;
  // Register placement on the CSR port and the management port
  localparam logic [8:0] CSR_OFFSET = 9'h1DC;
  localparam logic [4:0] MGT_INDEX = 5'h1F;
  localparam int MGT_WIDTH = 16;

  // Field positions
  localparam int BIT_LOOPBACK = 14;
  localparam int BIT_COL_TEST = 7;
  localparam int BIT_FULL_DUPLEX = 4;
  localparam int FLD_SPEED_HI = 3;
  localparam int FLD_SPEED_LO = 2;
  localparam int BIT_HB_DISABLE = 0;

  // Reset values
  localparam logic RST_LOOPBACK = 1'h0;
  localparam logic RST_COL_TEST = 1'h0;
  localparam logic RST_HB_DISABLE = 1'h0;

  // Speed codes of bits 3:2
  localparam logic [1:0] SPEED_10 = 2'h1;
  localparam logic [1:0] SPEED_100 = 2'h2;

  // Strap path and boot sequence
  localparam int SYNC_STAGES = 2;

  typedef enum logic [3:0] {
    VPS_SYNC1 = 4'h1,
    VPS_SYNC2 = 4'h2,
    VPS_LOAD = 4'h4,
    VPS_RUN = 4'h8
  } vps_fsm_t;
endpackage
`default_nettype wire

/* logic/vps_special_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module vps_special_ctrl #(
  parameter int ADDR_W = 9,
  parameter int DATA_W = 4
) (
  // Clock, reset, enable
  input wire logic I_CLK_SYS,
  input wire logic I_RST_B,
  input wire logic I_CE,
  // Configuration strap pin
  input wire logic I_HB_DISABLE_STRAP,
  // CSR access
  input wire logic I_CSR_REQ,
  input wire logic I_CSR_WR,
  input wire logic [ADDR_W-1:0] I_CSR_ADDR,
  input wire logic [31:0] I_CSR_WDATA,
  output logic O_CSR_ACK,
  output logic [31:0] O_CSR_RDATA,
  // Management access
  input wire logic I_MGT_REQ,
  input wire logic I_MGT_WR,
  input wire logic [4:0] I_MGT_REG,
  input wire logic [15:0] I_MGT_WDATA,
  output logic O_MGT_ACK,
  output logic [15:0] O_MGT_RDATA,
  // Emulated PHY control and negotiation outcome
  input wire logic I_VPHY_AUTONEG_ENABLE,
  input wire logic I_SPEED_SELECT_LOW,
  input wire logic I_DUPLEX_SELECT,
  input wire logic I_AN_RESULT_100,
  input wire logic I_AN_RESULT_FULL,
  input wire logic I_AN_FAIL,
  input wire logic I_VPHY_SOFT_RESET,
  input wire logic I_VPHY_HARD_RESET,
  output logic O_HEARTBEAT_TEST_DISABLE,
  output logic O_LP_AUTONEG_ABLE,
  output logic [2:0] O_SPEED_DUPLEX,
  // Switch fabric host port
  input wire logic I_SW_TX_EN,
  input wire logic [DATA_W-1:0] I_SW_TXD,
  output logic O_SW_COL,
  output logic O_SW_LB_DV,
  output logic [DATA_W-1:0] O_SW_LB_D,
  // Host MAC receive side
  output logic O_MAC_RX_DV,
  output logic [DATA_W-1:0] O_MAC_RXD
);
  typedef struct packed {
    vps_pkg::vps_fsm_t fsm;
    logic loopback;
    logic col_test;
    logic hb_disable;
    logic csr_ack;
    logic [31:0] csr_rdata;
    logic mgt_ack;
    logic [15:0] mgt_rdata;
    logic lp_able;
    logic [2:0] speed_duplex;
    logic col;
    logic lb_dv;
    logic [DATA_W-1:0] lb_d;
    logic mac_dv;
    logic [DATA_W-1:0] mac_d;
  } vps_ctrl_state_t;

  localparam vps_ctrl_state_t RST_STATE = '{
    fsm: vps_pkg::VPS_SYNC1,
    loopback: vps_pkg::RST_LOOPBACK,
    col_test: vps_pkg::RST_COL_TEST,
    hb_disable: vps_pkg::RST_HB_DISABLE,
    default: '0
  };

  if (ADDR_W < 9) begin : g_addr_check
    $error("vps_special_ctrl: ADDR_W must reach offset 1DC");
  end
  if (DATA_W < 1) begin : g_data_check
    $error("vps_special_ctrl: DATA_W must be at least 1");
  end

  vps_ctrl_state_t st;
  vps_ctrl_state_t next_st;
  vps_sync_if #(.W(1)) strap_if ();

  logic csr_hit;
  logic mgt_hit;
  logic csr_wr;
  logic mgt_wr;
  logic [15:0] wr_data;
  logic [2:0] speed_duplex;
  logic [31:0] rd_word;

  // The strap is a pin, so it is synchronised before use
  assign strap_if.async_in = I_HB_DISABLE_STRAP;

  vps_sync #(
    .W(1)
  ) u_strap_sync (
    .i_clk(I_CLK_SYS),
    .i_rst_b(I_RST_B),
    .i_ce(I_CE),
    .port(strap_if.dst)
  );

  assign csr_hit = I_CSR_REQ &&
    (I_CSR_ADDR == ADDR_W'(vps_pkg::CSR_OFFSET));
  assign mgt_hit = I_MGT_REQ && (I_MGT_REG == vps_pkg::MGT_INDEX);
  assign csr_wr = csr_hit && I_CSR_WR;
  assign mgt_wr = mgt_hit && I_MGT_WR;
  // Only the low half is ever stored; the CSR wins a same-cycle collision
  assign wr_data = csr_wr ? I_CSR_WDATA[15:0] : I_MGT_WDATA;

  always_comb begin
    if (I_VPHY_AUTONEG_ENABLE) begin
      speed_duplex = {I_AN_RESULT_FULL,
        I_AN_RESULT_100 ? vps_pkg::SPEED_100 : vps_pkg::SPEED_10};
    end else begin
      speed_duplex = {I_DUPLEX_SELECT,
        I_SPEED_SELECT_LOW ? vps_pkg::SPEED_100 : vps_pkg::SPEED_10};
    end
  end

  // Anything not assigned below is reserved and reads zero
  always_comb begin
    rd_word = '0;
    rd_word[vps_pkg::BIT_LOOPBACK] = st.loopback;
    rd_word[vps_pkg::BIT_COL_TEST] = st.col_test;
    rd_word[vps_pkg::BIT_FULL_DUPLEX:vps_pkg::FLD_SPEED_LO] = speed_duplex;
    rd_word[vps_pkg::BIT_HB_DISABLE] = st.hb_disable;
  end

  always_comb begin
    next_st = st;
    next_st.csr_ack = csr_hit;
    next_st.mgt_ack = mgt_hit;
    if (csr_hit && !I_CSR_WR) begin
      next_st.csr_rdata = rd_word;
    end
    if (mgt_hit && !I_MGT_WR) begin
      next_st.mgt_rdata = rd_word[vps_pkg::MGT_WIDTH-1:0];
    end
    if (csr_wr || mgt_wr) begin
      next_st.loopback = wr_data[vps_pkg::BIT_LOOPBACK];
      next_st.col_test = wr_data[vps_pkg::BIT_COL_TEST];
      next_st.hb_disable = wr_data[vps_pkg::BIT_HB_DISABLE];
    end
    // Soft reset clears ordinary bits but leaves heartbeat-disable alone
    if (I_VPHY_SOFT_RESET) begin
      next_st.loopback = vps_pkg::RST_LOOPBACK;
      next_st.col_test = vps_pkg::RST_COL_TEST;
    end
    unique case (st.fsm)
      vps_pkg::VPS_SYNC1: next_st.fsm = vps_pkg::VPS_SYNC2;
      vps_pkg::VPS_SYNC2: next_st.fsm = vps_pkg::VPS_LOAD;
      vps_pkg::VPS_LOAD: begin
        // Strap is settled by now; a write in this cycle loses bit 0
        next_st.hb_disable = strap_if.sync_out[0];
        next_st.fsm = vps_pkg::VPS_RUN;
      end
      vps_pkg::VPS_RUN: next_st.fsm = vps_pkg::VPS_RUN;
      default: next_st.fsm = vps_pkg::VPS_SYNC1;
    endcase
    // Hard reset outranks everything and reloads the strap
    if (I_VPHY_HARD_RESET) begin
      next_st.loopback = vps_pkg::RST_LOOPBACK;
      next_st.col_test = vps_pkg::RST_COL_TEST;
      next_st.hb_disable = vps_pkg::RST_HB_DISABLE;
      next_st.fsm = vps_pkg::VPS_LOAD;
    end
    next_st.lp_able = !I_AN_FAIL;
    next_st.speed_duplex = speed_duplex;
    next_st.col = st.col_test && I_SW_TX_EN;
    if (st.loopback) begin
      next_st.lb_dv = I_SW_TX_EN;
      next_st.lb_d = I_SW_TXD;
      next_st.mac_dv = 1'h0;
      next_st.mac_d = '0;
    end else begin
      next_st.lb_dv = 1'h0;
      next_st.lb_d = '0;
      next_st.mac_dv = I_SW_TX_EN;
      next_st.mac_d = I_SW_TXD;
    end
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      st <= RST_STATE;
    end else if (I_CE) begin
      st <= next_st;
    end
  end

  assign O_CSR_ACK = st.csr_ack;
  assign O_CSR_RDATA = st.csr_rdata;
  assign O_MGT_ACK = st.mgt_ack;
  assign O_MGT_RDATA = st.mgt_rdata;
  assign O_HEARTBEAT_TEST_DISABLE = st.hb_disable;
  assign O_LP_AUTONEG_ABLE = st.lp_able;
  assign O_SPEED_DUPLEX = st.speed_duplex;
  assign O_SW_COL = st.col;
  assign O_SW_LB_DV = st.lb_dv;
  assign O_SW_LB_D = st.lb_d;
  assign O_MAC_RX_DV = st.mac_dv;
  assign O_MAC_RXD = st.mac_d;

  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (!I_RST_B);

  sequence s_csr_read;
    I_CE && csr_hit && !I_CSR_WR;
  endsequence

  sequence s_hard_reset;
    I_CE && I_VPHY_HARD_RESET;
  endsequence

  sequence s_strap_reload;
    I_CE && st.fsm == vps_pkg::VPS_LOAD ##1 I_CE;
  endsequence

  a_csr_read_word: assert property (
    s_csr_read |=> O_CSR_ACK && O_CSR_RDATA == $past(rd_word))
    else $error("CSR read at register offset returned wrong word");

  a_mgt_read_half: assert property (
    I_CE && mgt_hit && !I_MGT_WR |=> O_MGT_ACK &&
      O_MGT_RDATA == $past(rd_word[15:0]))
    else $error("Management read returned wrong half word");

  a_reserved_read_zero: assert property (
    O_CSR_ACK |-> (O_CSR_RDATA & 32'hFFFF_BF62) == 32'h0000_0000)
    else $error("Reserved bits read nonzero");

  a_loopback_path: assert property (
    I_CE && st.loopback && I_SW_TX_EN |=> !O_MAC_RX_DV && O_SW_LB_DV &&
      O_SW_LB_D == $past(I_SW_TXD))
    else $error("Looped frame reached the host MAC");

  a_collision_test: assert property (
    I_CE |=> O_SW_COL == ($past(st.col_test) && $past(I_SW_TX_EN)))
    else $error("Collision does not track transmit under test");

  a_speed_autoneg: assert property (
    s_csr_read ##0 I_VPHY_AUTONEG_ENABLE |=>
      O_CSR_RDATA[4:2] == {$past(I_AN_RESULT_FULL), $past(I_AN_RESULT_100),
        !$past(I_AN_RESULT_100)})
    else $error("Speed field ignores negotiation outcome");

  a_speed_forced: assert property (
    s_csr_read ##0 !I_VPHY_AUTONEG_ENABLE |=>
      O_CSR_RDATA[4:2] == {$past(I_DUPLEX_SELECT),
        $past(I_SPEED_SELECT_LOW), !$past(I_SPEED_SELECT_LOW)})
    else $error("Speed field ignores select bits");

  a_heartbeat_write: assert property (
    I_CE && csr_wr && !I_VPHY_HARD_RESET && st.fsm == vps_pkg::VPS_RUN
      |=> O_HEARTBEAT_TEST_DISABLE == $past(I_CSR_WDATA[0]))
    else $error("Heartbeat disable did not take the written value");

  a_strap_load: assert property (
    s_strap_reload ##0 !$past(I_VPHY_HARD_RESET) |->
      O_HEARTBEAT_TEST_DISABLE == $past(strap_if.sync_out[0]))
    else $error("Heartbeat disable not loaded from strap");

  // A frozen or repeated reset cycle legally keeps the machine in LOAD
  a_hard_reset_all: assert property (
    s_hard_reset |=> !st.loopback && !st.col_test && !st.hb_disable &&
      st.fsm == vps_pkg::VPS_LOAD ##1 (!$past(I_CE) ||
      $past(I_VPHY_HARD_RESET) || st.fsm == vps_pkg::VPS_RUN))
    else $error("Hard reset did not clear and reload");

  a_soft_keeps_hb: assert property (
    I_CE && I_VPHY_SOFT_RESET && !I_VPHY_HARD_RESET && !csr_wr && !mgt_wr &&
      st.fsm == vps_pkg::VPS_RUN |=> $stable(O_HEARTBEAT_TEST_DISABLE) &&
      !st.loopback && !st.col_test)
    else $error("Soft reset disturbed heartbeat disable");

  a_partner_able: assert property (
    I_CE |=> O_LP_AUTONEG_ABLE == !$past(I_AN_FAIL))
    else $error("Partner ability does not follow failure");

  a_host_path: assert property (
    I_CE && !st.loopback |=> !O_SW_LB_DV && O_MAC_RX_DV == $past(I_SW_TX_EN)
      && O_MAC_RXD == $past(I_SW_TXD))
    else $error("Host frame did not reach the host MAC");

  a_csr_wins: assert property (
    I_CE && csr_wr && mgt_wr && !I_VPHY_SOFT_RESET && !I_VPHY_HARD_RESET |=>
      st.loopback == $past(I_CSR_WDATA[vps_pkg::BIT_LOOPBACK]))
    else $error("Management write overrode a same-cycle CSR write");
endmodule
`default_nettype wire

/* logic/vps_sync.sv */
`timescale 1ns/10ps
`default_nettype none
module vps_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  // Crossing
  vps_sync_if.dst port
);
  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } vps_sync_state_t;

  vps_sync_state_t st;
  vps_sync_state_t next_st;

  if (W < 1) begin : g_check
    $error("vps_sync: W must be at least 1");
  end

  // Stage1 feeds stage2 only, nothing else looks at it
  always_comb begin
    next_st = st;
    next_st.stage1 = port.async_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else if (i_ce) begin
      st <= next_st;
    end
  end

  assign port.sync_out = st.stage2;
endmodule
`default_nettype wire

/* logic/vps_sync_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface vps_sync_if #(
  parameter int W = 1
);
  logic [W-1:0] async_in;
  logic [W-1:0] sync_out;
  modport src (output async_in, input sync_out);
  modport dst (input async_in, output sync_out);
endinterface
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [8:0] OFF = vps_pkg::CSR_OFFSET;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic ce = 1'h1;
  logic strap = 1'h1;
  logic creq = 1'h0, cwr = 1'h0, mreq = 1'h0, mwr = 1'h0;
  logic [8:0] caddr = 9'h000;
  logic [31:0] cwd = 32'h0, crd;
  logic [4:0] mreg = 5'h00;
  logic [15:0] mwd = 16'h0, mrd;
  logic an = 1'h0, sel = 1'h0, dup = 1'h0, r100 = 1'h0, rfull = 1'h0;
  logic fail = 1'h0, srst = 1'h0, hrst = 1'h0;
  logic cack, mack, hb, lpa, col, lbdv, macdv, txen, s_en;
  logic [2:0] spd;
  logic [3:0] lbd, macd, txd, s_d;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  initial forever #12.5 clk = ~clk;
  vps_special_ctrl i_vps_special_ctrl (.I_CLK_SYS(clk), .I_RST_B(rst_b),
    .I_CE(ce), .I_HB_DISABLE_STRAP(strap), .I_CSR_REQ(creq),
    .I_CSR_WR(cwr), .I_CSR_ADDR(caddr), .I_CSR_WDATA(cwd),
    .O_CSR_ACK(cack), .O_CSR_RDATA(crd), .I_MGT_REQ(mreq),
    .I_MGT_WR(mwr), .I_MGT_REG(mreg), .I_MGT_WDATA(mwd),
    .O_MGT_ACK(mack), .O_MGT_RDATA(mrd), .I_VPHY_AUTONEG_ENABLE(an),
    .I_SPEED_SELECT_LOW(sel), .I_DUPLEX_SELECT(dup),
    .I_AN_RESULT_100(r100), .I_AN_RESULT_FULL(rfull), .I_AN_FAIL(fail),
    .I_VPHY_SOFT_RESET(srst), .I_VPHY_HARD_RESET(hrst),
    .O_HEARTBEAT_TEST_DISABLE(hb), .O_LP_AUTONEG_ABLE(lpa),
    .O_SPEED_DUPLEX(spd), .I_SW_TX_EN(txen), .I_SW_TXD(txd),
    .O_SW_COL(col), .O_SW_LB_DV(lbdv), .O_SW_LB_D(lbd),
    .O_MAC_RX_DV(macdv), .O_MAC_RXD(macd));
  vps_fabric_model i_vps_fabric_model (.i_clk(clk), .o_tx_en(txen),
    .o_txd(txd));
  always @(posedge clk) begin
    s_en <= txen;
    s_d <= txd;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One-cycle request; the ack and data are settled by the next fall
  task automatic acc(input logic m, w, input logic [8:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic k);
    @(negedge clk);
    {creq, mreq, cwr, mwr, caddr, mreg} = {!m, m, w, w, a, a[4:0]};
    {cwd, mwd} = {d, d[15:0]};
    @(negedge clk);
    {creq, mreq} = 2'h0;
    k = m ? mack : cack;
    q = m ? {16'h0, mrd} : crd;
  endtask
  task automatic xw(input logic m, input logic [8:0] a,
      input logic [31:0] d, input logic hit);
    logic [31:0] q;
    logic k;
    acc(m, 1'h1, a, d, q, k);
    chk("write ack", hit, k);
  endtask
  task automatic xr(input logic m, input logic [8:0] a,
      input logic [31:0] e);
    logic [31:0] q;
    logic k;
    acc(m, 1'h0, a, 32'h0, q, k);
    chk("read ack", 1'h1, k);
    chk("read data", e, q);
  endtask
  task automatic pulse(input logic hard);
    @(negedge clk);
    {hrst, srst} = {hard, !hard};
    @(negedge clk);
    {hrst, srst} = 2'h0;
    repeat (3) @(negedge clk);
  endtask
  task automatic t_boot;
    xr(1'h0, OFF, 32'h5);
    chk("hb out", 1'h1, hb);
  endtask
  task automatic t_csr;
    xw(1'h0, OFF, 32'hFFFFFFFF, 1'h1);
    xr(1'h0, OFF, 32'h4085);
    xw(1'h0, 9'h1D8, 32'h0, 1'h0);
    xw(1'h0, OFF, 32'h0, 1'h1);
    chk("hb out", 1'h0, hb);
    // Let the last ack fall first, a frozen block would hold it high
    @(negedge clk);
    ce = 1'h0;
    xw(1'h0, OFF, 32'h1, 1'h0);
    ce = 1'h1;
    xr(1'h0, OFF, 32'h4);
  endtask
  task automatic t_mgt;
    xw(1'h1, 9'h01F, 32'hFFFF, 1'h1);
    xr(1'h0, OFF, 32'h4085);
    xw(1'h1, 9'h01E, 32'h0, 1'h0);
    xr(1'h1, 9'h01F, 32'h4085);
  endtask
  task automatic t_both;
    @(negedge clk);
    {creq, cwr, caddr, cwd} = {2'h3, OFF, 32'h0};
    {mreq, mwr, mreg, mwd} = {2'h3, 5'h1F, 16'h4081};
    @(negedge clk);
    {creq, mreq} = 2'h0;
    chk("both acks", 2'h3, {cack, mack});
    xr(1'h0, OFF, 32'h4);
  endtask
  task automatic t_speed;
    logic [31:0] q;
    logic k;
    logic [2:0] e;
    for (int i = 0; i < 32; i++) begin
      {an, sel, dup, r100, rfull} = i[4:0];
      fail = !an & i[0];
      e = an ? {rfull, r100, !r100} : {dup, sel, !sel};
      acc(1'h0, 1'h0, OFF, 32'h0, q, k);
      chk("field", e, q[4:2]);
      chk("speed out", e, spd);
      chk("lp able", !fail, lpa);
    end
    // Later reads expect the forced 10 Mbps half-duplex code
    {an, sel, dup, r100, rfull, fail} = 6'h0;
  endtask
  task automatic t_data;
    logic lb, ct;
    for (int i = 0; i < 4; i++) begin
      {lb, ct} = i[1:0];
      xw(1'h0, OFF, {17'h0, lb, 6'h0, ct, 7'h0}, 1'h1);
      fork
        i_vps_fabric_model.send(5);
        repeat (8) begin
          @(negedge clk);
          chk("lb dv", s_en & lb, lbdv);
          chk("mac dv", s_en & !lb, macdv);
          chk("col", s_en & ct, col);
          if (s_en) chk("nibble", s_d, lb ? lbd : macd);
          chk("idle nibble", 4'h0, lb ? macd : lbd);
        end
      join
    end
  endtask
  task automatic t_rst;
    xw(1'h0, OFF, 32'h4081, 1'h1);
    strap = 1'h0;
    pulse(1'h0);
    xr(1'h0, OFF, 32'h5);
    xw(1'h0, OFF, 32'h4081, 1'h1);
    pulse(1'h1);
    xr(1'h0, OFF, 32'h4);
    strap = 1'h1;
    pulse(1'h1);
    xr(1'h0, OFF, 32'h5);
    @(negedge clk);
    rst_b = 1'h0;
    @(negedge clk);
    chk("reset hb", 1'h0, hb);
    rst_b = 1'h1;
    repeat (4) @(negedge clk);
    xr(1'h0, OFF, 32'h5);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'h1;
    repeat (4) @(negedge clk);
    t_boot();
    t_csr();
    t_mgt();
    t_both();
    t_speed();
    t_data();
    t_rst();
    print_verdict();
  end
endmodule
`default_nettype wire

/* tb/vps_fabric_model.sv */
`timescale 1ns/10ps
`default_nettype none
module vps_fabric_model (
  // Clock
  input wire logic i_clk,
  // Switch transmit toward host port
  output logic o_tx_en,
  output logic [3:0] o_txd
);
  initial begin
    o_tx_en = 1'h0;
    o_txd = 4'h0;
  end
  task automatic send(input int n);
    for (int k = 0; k < n; k++) begin
      @(negedge i_clk);
      o_tx_en = 1'h1;
      o_txd = o_txd + 4'h3;
    end
    @(negedge i_clk);
    o_tx_en = 1'h0;
    // Stale nibble is inverted so a late sample cannot match by luck
    o_txd = ~o_txd;
  endtask
endmodule
`default_nettype wire
